// *** hdl/sqf_defs.svh ***
// Constant definitions for the squitter filter serializer
`ifndef SQF_DEFS_SVH
`define SQF_DEFS_SVH
`define SQF_CLK_HZ        40000000
`define SQF_BAUD          230400
`define SQF_BIT_CYC       (`SQF_CLK_HZ / `SQF_BAUD)
`define SQF_CHIP_HZ       2000000
`define SQF_CHIP_CYC      (`SQF_CLK_HZ / `SQF_CHIP_HZ)
`define SQF_FRAME_BITS    112
`define SQF_DATA_BITS     88
`define SQF_CRC_BITS      24
`define SQF_CRC_POLY      24'hfff409
`define SQF_FMT_EXT       5'h11
`define SQF_PREAMBLE      16'ha140
`define SQF_CH_PREFIX     8'h2a
`define SQF_CH_SEMI       8'h3b
`define SQF_CH_CR         8'h0d
`define SQF_CH_LF         8'h0a
`define SQF_ASCII_LEN     32
`define SQF_BIN_LEN       18
`endif

// *** hdl/sqf_pkg.sv ***
// Types shared by the squitter filter serializer
package sqf_pkg;
   typedef enum logic [3:0]
   {
      SQF_HUNT  = 4'b0001,
      SQF_BITS  = 4'b0010,
      SQF_CHECK = 4'b0100,
      SQF_SEND  = 4'b1000
   } sqf_state_e;
   typedef logic [111:0] sqf_frame_t;
endpackage

// *** hdl/sqf_squitter_serializer.sv ***
// Squitter capture, format and CRC filter, ASCII or binary UART output
//
// Functional notes
// R1 - Scan baseband for header, then capture the following 112 bits.
// R2 - Demodulate at one megabit per second from half-bit chip samples.
// R3 - Check format field; only extended squitter format is checked further.
// R4 - Send datagram only when computed CRC equals received CRC.
// R5 - Activity LED on while a sentence is transmitted, else off.
// R6 - Format filter is fixed; no way to change accepted format.
// R7 - UART framing 230400 baud, start, eight data, no parity, one stop.
// R8 - Baud rate is a build-time parameter only.
// R9 - ASCII mode sends each byte as high nibble then low nibble.
// R10 - Transmit only; no receive input or configuration path.
// R11 - Sentence starts with asterisk, ends with semicolon, CR, LF.
// R12 - Build-time option sends raw binary bytes instead of hex.
// R13 - ASCII sentence is fixed at 32 characters.
// R14 - Binary sentence is fixed at 18 bytes.
// R15 - Hex letters upper case; bytes sent in received order.
// R16 - CRC uses 24-bit squitter polynomial over 88 bits.
`timescale 1ns/1ps
`include "sqf_defs.svh"

// ====================================================================
// Small FIFO
module sqf_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
)
(
   input  wire logic             mclk_in,
   input  wire logic             rst_n_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   assign in_ready_out  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid_out = (cnt_q != '0);
   assign push = in_valid_in && in_ready_out;
   assign pop  = out_valid_out && out_ready_in;
   assign out_data_out = mem_q[rd_q];

   always_ff @(posedge mclk_in)
   begin
      if (push)
         mem_q[wr_q] <= in_data_in;
   end

   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in)
      begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         if (pop)
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ====================================================================
// Receiver and serializer top
module sqf_squitter_serializer
#(
   parameter int  BIT_CYC  = `SQF_BIT_CYC,
   parameter int  CHIP_CYC = `SQF_CHIP_CYC,
   parameter bit  BINARY   = 1'b0,
   parameter int  FIFO_D   = 4
)
(
   input  wire logic mclk_in,
   input  wire logic rst_n_in,
   input  wire logic baseband_in,
   output logic      tx_out,
   output logic      led_out
);
   // R10 transmit only
   // No receive pin exists; nothing configures the block at run time.

   // =================================================================
   // Input synchroniser
   logic s1_q, s2_q, s3_q, bb_q;
   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         bb_q <= 1'b0;
      end
      else
      begin
         s1_q <= baseband_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q)
            bb_q <= s3_q;
      end
   end

   // =================================================================
   // Chip sampling
   // R2 chip strobe
   // Free-running strobe; no resync, so input must be chip-aligned.
   logic [7:0] chip_cnt_q;
   logic       chip_stb;
   assign chip_stb = (chip_cnt_q == 8'(CHIP_CYC - 1));
   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in)
         chip_cnt_q <= '0;
      else
         chip_cnt_q <= chip_stb ? '0 : chip_cnt_q + 8'h01;
   end

   // =================================================================
   // Capture machine
   sqf_pkg::sqf_state_e st_q;
   logic [15:0]         hdr_q;
   logic [111:0]        frm_q;
   logic [6:0]          nbit_q;
   logic                half_q;
   logic                first_q;
   logic [6:0]          crc_i_q;
   logic [23:0]         crc_q;
   logic                send_go;
   logic                send_busy;

   function automatic logic [23:0] crc_step(input logic [23:0] c,
                                           input logic        b);
      logic fb;
      fb = c[23] ^ b;
      crc_step = {c[22:0], 1'b0} ^ (fb ? `SQF_CRC_POLY : 24'h000000);
   endfunction

   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in)
      begin
         st_q    <= sqf_pkg::SQF_HUNT;
         hdr_q   <= '0;
         frm_q   <= '0;
         nbit_q  <= '0;
         half_q  <= 1'b0;
         first_q <= 1'b0;
         crc_i_q <= '0;
         crc_q   <= '0;
      end
      else
      begin
         case (st_q)
            sqf_pkg::SQF_HUNT:
            begin
               // R1 header search
               if (chip_stb)
               begin
                  hdr_q <= {hdr_q[14:0], bb_q};
                  if ({hdr_q[14:0], bb_q} == `SQF_PREAMBLE)
                  begin
                     st_q   <= sqf_pkg::SQF_BITS;
                     nbit_q <= '0;
                     half_q <= 1'b0;
                  end
               end
            end
            sqf_pkg::SQF_BITS:
            begin
               // R2 pulse position bit decision
               if (chip_stb)
               begin
                  half_q <= ~half_q;
                  if (!half_q)
                     first_q <= bb_q;
                  else
                  begin
                     frm_q  <= {frm_q[110:0], first_q};
                     nbit_q <= nbit_q + 7'h01;
                     if (nbit_q == 7'(`SQF_FRAME_BITS - 1))
                     begin
                        st_q    <= sqf_pkg::SQF_CHECK;
                        crc_i_q <= '0;
                        crc_q   <= '0;
                     end
                  end
               end
            end
            sqf_pkg::SQF_CHECK:
            begin
               // R3 R6 fixed format filter
               if (frm_q[111:107] != `SQF_FMT_EXT)
               begin
                  st_q  <= sqf_pkg::SQF_HUNT;
                  hdr_q <= '0;
               end
               else if (crc_i_q != 7'(`SQF_DATA_BITS))
               begin
                  // R16 serial CRC
                  crc_q   <= crc_step(crc_q, frm_q[7'd111 - crc_i_q]);
                  crc_i_q <= crc_i_q + 7'h01;
               end
               // R4 CRC compare gate
               else if (crc_q == frm_q[23:0] && !send_busy)
                  st_q <= sqf_pkg::SQF_SEND;
               else
               begin
                  st_q  <= sqf_pkg::SQF_HUNT;
                  hdr_q <= '0;
               end
            end
            sqf_pkg::SQF_SEND:
            begin
               st_q  <= sqf_pkg::SQF_HUNT;
               hdr_q <= '0;
            end
            default:
               st_q <= sqf_pkg::SQF_HUNT;
         endcase
      end
   end
   assign send_go = (st_q == sqf_pkg::SQF_SEND);

   // =================================================================
   // Sentence builder
   localparam int LEN = BINARY ? `SQF_BIN_LEN : `SQF_ASCII_LEN;
   logic [111:0] out_frm_q;
   logic [5:0]   idx_q;
   logic         act_q;
   logic [7:0]   ch;
   logic         f_ready;
   logic         f_valid;
   logic [7:0]   f_data;
   logic         u_busy;
   logic         f_valid_o;

   // R9 R15 upper case hex digit
   function automatic logic [7:0] hex_char(input logic [3:0] n);
      hex_char = (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
   endfunction

   always_comb
   begin
      logic [5:0] k;
      logic [7:0] byt;
      k   = idx_q - 6'h01;
      byt = 8'h00;
      ch  = 8'h00;
      // R11 prefix and suffix
      if (idx_q == 6'h00)
         ch = `SQF_CH_PREFIX;
      else if (idx_q == 6'(LEN - 3))
         ch = `SQF_CH_SEMI;
      else if (idx_q == 6'(LEN - 2))
         ch = `SQF_CH_CR;
      else if (idx_q == 6'(LEN - 1))
         ch = `SQF_CH_LF;
      else if (BINARY)
      begin
         // R12 R14 raw bytes in order
         byt = out_frm_q[8'd111 - {k[4:0], 3'b000} -: 8];
         ch  = byt;
      end
      else
      begin
         // R9 R13 nibble pairs, high first
         byt = out_frm_q[8'd111 - {k[5:1], 3'b000} -: 8];
         ch  = k[0] ? hex_char(byt[3:0]) : hex_char(byt[7:4]);
      end
   end

   assign send_busy = act_q;
   assign f_valid   = act_q;

   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in)
      begin
         out_frm_q <= '0;
         idx_q     <= '0;
         act_q     <= 1'b0;
      end
      else if (send_go)
      begin
         out_frm_q <= frm_q;
         idx_q     <= '0;
         act_q     <= 1'b1;
      end
      else if (act_q && f_ready)
      begin
         idx_q <= idx_q + 6'h01;
         if (idx_q == 6'(LEN - 1))
            act_q <= 1'b0;
      end
   end

   sqf_fifo #(.WIDTH(8), .DEPTH(FIFO_D)) u_fifo
   (
      .mclk_in       (mclk_in),
      .rst_n_in      (rst_n_in),
      .in_valid_in   (f_valid),
      .in_ready_out  (f_ready),
      .in_data_in    (ch),
      .out_valid_out (f_valid_o),
      .out_ready_in  (!u_busy),
      .out_data_out  (f_data)
   );

   // =================================================================
   // UART transmitter
   // R7 R8 fixed 8N1 framing
   logic [9:0]  sh_q;
   logic [3:0]  nb_q;
   logic [15:0] bc_q;
   logic        tx_q;
   logic        led_q;
   assign u_busy = (nb_q != 4'h0);
   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in)
      begin
         sh_q <= '1;
         nb_q <= '0;
         bc_q <= '0;
         tx_q <= 1'b1;
      end
      else if (!u_busy)
      begin
         if (f_valid_o)
         begin
            sh_q <= {1'b1, f_data, 1'b0};
            nb_q <= 4'd10;
            bc_q <= '0;
            tx_q <= 1'b0;
         end
      end
      else if (bc_q == 16'(BIT_CYC - 1))
      begin
         bc_q <= '0;
         sh_q <= {1'b1, sh_q[9:1]};
         nb_q <= nb_q - 4'h1;
         tx_q <= (nb_q == 4'h1) ? 1'b1 : sh_q[1];
      end
      else
         bc_q <= bc_q + 16'h0001;
   end

   // R5 activity indicator
   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in)
         led_q <= 1'b0;
      else
         led_q <= act_q || f_valid_o || u_busy;
   end
   assign tx_out  = tx_q;
   assign led_out = led_q;

   // =================================================================
   // Checks
   a_led_follows: assert property (@(posedge mclk_in) disable iff
      (!rst_n_in) u_busy |=> led_q) else $error("led off during send"); // R5
   a_idle_high: assert property (@(posedge mclk_in) disable iff
      (!rst_n_in) !u_busy && !$past(u_busy) |-> tx_q)
      else $error("line not idle high"); // R7
   a_fmt_drop: assert property (@(posedge mclk_in) disable iff
      (!rst_n_in) st_q == sqf_pkg::SQF_CHECK &&
      frm_q[111:107] != `SQF_FMT_EXT |=> st_q == sqf_pkg::SQF_HUNT)
      else $error("wrong format kept"); // R3
   a_crc_gate: assert property (@(posedge mclk_in) disable iff
      (!rst_n_in) send_go |-> $past(crc_q) == frm_q[23:0])
      else $error("bad crc sent"); // R4
   a_first_prefix: assert property (@(posedge mclk_in) disable iff
      (!rst_n_in) act_q && idx_q == 6'h00 |-> ch == `SQF_CH_PREFIX)
      else $error("prefix wrong"); // R11
   a_last_lf: assert property (@(posedge mclk_in) disable iff
      (!rst_n_in) act_q && idx_q == 6'(LEN - 1) |-> ch == `SQF_CH_LF)
      else $error("suffix wrong"); // R11
   a_start_bit: assert property (@(posedge mclk_in) disable iff
      (!rst_n_in) !u_busy && f_valid_o |=> !tx_q [*2])
      else $error("start bit missing"); // R7
   a_hex_case: assert property (@(posedge mclk_in) disable iff
      (!rst_n_in) act_q && !BINARY && idx_q > 6'h00 && idx_q < 6'd29 |->
      (ch inside {[8'h30:8'h39], [8'h41:8'h46]}))
      else $error("bad hex char"); // R15
   c_send: cover property (@(posedge mclk_in) send_go);
   c_drop: cover property (@(posedge mclk_in)
      st_q == sqf_pkg::SQF_CHECK ##1 st_q == sqf_pkg::SQF_HUNT);
   c_full: cover property (@(posedge mclk_in) act_q && !f_ready);
endmodule

// *** verif/sqf_uart_rx_model.sv ***
// Host side UART receiver model for the squitter serializer bench
`timescale 1ns/1ps
// ==============================================================
// Receiver model, samples mid-bit on the falling clock edge
module sqf_uart_rx_model
#(
   parameter int BIT_CYC = 16
)
(
   input  wire logic       mclk_in,
   input  wire logic       line_in,
   output logic      [7:0] byte_out,
   output logic            strobe_out,
   output logic            err_out
);
   initial
   begin
      byte_out   = 8'h00;
      strobe_out = 1'b0;
      err_out    = 1'b0;
      forever
      begin
         @(negedge mclk_in);
         strobe_out = 1'b0;
         if (line_in === 1'b0)
         begin
            repeat (BIT_CYC / 2) @(negedge mclk_in);
            err_out = (line_in !== 1'b0);
            for (int i = 0; i < 8; i++)
            begin
               repeat (BIT_CYC) @(negedge mclk_in);
               byte_out[i] = line_in;
            end
            repeat (BIT_CYC) @(negedge mclk_in);
            err_out    = err_out | (line_in !== 1'b1);
            strobe_out = 1'b1;
         end
      end
   end
endmodule

// *** verif/tb_squitter_filter_ascii_serializer.sv ***
// Self-checking bench for the squitter filter serializer
`timescale 1ns/1ps
`define CHK(g, e) \
   begin \
      n_checks++; \
      if ((g) !== (e)) \
      begin \
         errors++; \
         $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); \
      end \
   end
// ==============================================================
// Bench top
module tb_squitter_filter_ascii_serializer;
   // Short bit time keeps the run small
   localparam int BITC = 16;
   localparam int CHIP = 20;
   logic         mclk_in;
   logic         rst_n_in;
   logic         baseband_in;
   logic         tx_a, tx_b, led_a, led_b;
   logic         stb_a, stb_b, err_a, err_b;
   logic [7:0]   byte_a, byte_b;
   logic [8:0]   want;
   logic [31:0]  seed;
   logic [7:0]   exp_a[$];
   logic [7:0]   exp_b[$];
   logic [4:0]   fmts[6] = '{5'h11, 5'h11, 5'h0b, 5'h11, 5'h12, 5'h11};
   logic         bads[6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
   int           errors = 0;
   int           n_checks = 0;
   int           cyc = 0;

   // Chip rate and FIFO depth stay at their defaults; CHIP mirrors the chip
   sqf_squitter_serializer #(.BIT_CYC(BITC)) u_dut (.mclk_in(mclk_in),
      .rst_n_in(rst_n_in), .baseband_in(baseband_in),
      .tx_out(tx_a), .led_out(led_a));
   sqf_squitter_serializer #(.BIT_CYC(BITC),
      .BINARY(1'b1)) u_bin (.mclk_in(mclk_in),
      .rst_n_in(rst_n_in), .baseband_in(baseband_in),
      .tx_out(tx_b), .led_out(led_b));
   sqf_uart_rx_model #(.BIT_CYC(BITC)) u_rx_a (.mclk_in(mclk_in),
      .line_in(tx_a), .byte_out(byte_a), .strobe_out(stb_a),
      .err_out(err_a));
   sqf_uart_rx_model #(.BIT_CYC(BITC)) u_rx_b (.mclk_in(mclk_in),
      .line_in(tx_b), .byte_out(byte_b), .strobe_out(stb_b),
      .err_out(err_b));

   initial
   begin
      mclk_in = 1'b0;
      forever #12.5 mclk_in = ~mclk_in;
   end

   // Chip phase follows the design's free running chip counter
   // Counted on the rising edge so reset release cannot race it
   always @(posedge mclk_in)
      cyc <= rst_n_in ? cyc + 1 : 0;

   // ==============================================================
   // Received bytes against the model queues
   always @(posedge mclk_in)
   begin
      if (stb_a)
      begin
         `CHK({err_a, led_a}, 2'b01)
         want = exp_a.size() ? {1'b0, exp_a.pop_front()} : 9'h1ff;
         `CHK({1'b0, byte_a}, want)
      end
      if (stb_b)
      begin
         `CHK({err_b, led_b}, 2'b01)
         want = exp_b.size() ? {1'b0, exp_b.pop_front()} : 9'h1ff;
         `CHK({1'b0, byte_b}, want)
      end
   end

   // ==============================================================
   // Model helpers
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [7:0] hexc(input logic [3:0] n);
      return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
   endfunction

   function automatic logic [23:0] crc88(input logic [87:0] d);
      logic [23:0] c;
      c = 24'h000000;
      for (int i = 87; i >= 0; i--)
         c = {c[22:0], 1'b0} ^ ((d[i] ^ c[23]) ? 24'hfff409 : 24'h0);
      return c;
   endfunction

   task automatic push_exp(input logic [111:0] f);
      logic [7:0]  b;
      logic [23:0] sfx;
      sfx = 24'h3b0d0a;
      exp_a.push_back(8'h2a);
      exp_b.push_back(8'h2a);
      for (int i = 13; i >= 0; i--)
      begin
         b = f[i*8 +: 8];
         exp_a.push_back(hexc(b[7:4]));
         exp_a.push_back(hexc(b[3:0]));
         exp_b.push_back(b);
      end
      for (int k = 2; k >= 0; k--)
      begin
         exp_a.push_back(sfx[k*8 +: 8]);
         exp_b.push_back(sfx[k*8 +: 8]);
      end
   endtask

   task automatic chip(input logic v);
      baseband_in = v;
      repeat (CHIP) @(negedge mclk_in);
   endtask

   // Edges land mid-way between chip samples
   task automatic send(input logic [111:0] f);
      logic [15:0] hdr;
      hdr = 16'ha140;
      while (cyc % CHIP != 10)
         @(negedge mclk_in);
      for (int i = 15; i >= 0; i--)
         chip(hdr[i]);
      for (int i = 111; i >= 0; i--)
      begin
         chip(f[i]);
         chip(~f[i]);
      end
      chip(1'b0);
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ==============================================================
   // Main sequence
   initial
   begin
      logic [95:0]  r;
      logic [87:0]  d;
      logic [111:0] f;
      logic         ok;
      int           w;
      seed = 32'h6f2a;
      rst_n_in = 1'b0;
      baseband_in = 1'b0;
      repeat (5) @(posedge mclk_in);
      @(negedge mclk_in);
      `CHK({tx_a, tx_b, led_a, led_b}, 4'b1100)
      rst_n_in = 1'b1;
      repeat (40) @(negedge mclk_in);
      for (int t = 0; t < 6; t++)
      begin
         r = {xs(), xs(), xs()};
         d = {fmts[t], r[82:0]};
         f = {d, crc88(d) ^ (bads[t] ? 24'h000100 : 24'h000000)};
         ok = (fmts[t] == 5'h11) && !bads[t];
         if (ok)
            push_exp(f);
         send(f);
         // A dropped frame has no event to wait on; check takes ~89
         w = ok ? 0 : 20000 - 3000;
         while (w < 20000 && (!ok || exp_a.size() || exp_b.size()
                || led_a || led_b))
         begin
            @(negedge mclk_in);
            w++;
         end
         if (ok && w == 20000)
         begin
            errors++;
            break;
         end
         `CHK(exp_a.size() + exp_b.size(), 0)
         `CHK({led_a, led_b, tx_a, tx_b}, 4'b0011)
         $display("test %0d format %0h done", t, fmts[t]);
      end
      tally_and_finish();
   end
endmodule
